// >>> bench/cdd_clk_consumer.sv
/*
  Clock consumer model: measures the last high and low run of each clock
  in master cycles. Assumes the clocks are registered on the master clock.
*/
`default_nettype none
module cdd_clk_consumer #(
  parameter int W = 8
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [W-1:0]         clk_in,
  output var  logic [W-1:0][15:0]   hi_w,
  output var  logic [W-1:0][15:0]   lo_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0]       prev;
  logic [W-1:0][15:0] run;
  always_ff @(posedge clk) begin
    for (int i = 0; i < W; i++) begin
      if (!resetn) begin
        prev[i] <= 1'b0;
        run[i]  <= 16'h0001;
        hi_w[i] <= 16'h0000;
        lo_w[i] <= 16'h0000;
      end else if (clk_in[i] != prev[i]) begin
        prev[i] <= clk_in[i];
        run[i]  <= 16'h0001;
        if (prev[i])
          hi_w[i] <= run[i];
        else
          lo_w[i] <= run[i];
      end else begin
        run[i] <= run[i] + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/cdd_clock_dist_props.sv
/*
  Checker for the clock distribution top, bound from the bench top file.
  Assumes bus and cpu divide values stay at their reset value of two.
*/
`include "cdd_consts.svh"
`default_nettype none
module cdd_clock_dist_props #(
  parameter int SEC_EDGES = 4
) (
  input wire logic                   CLK,
  input wire logic                   RESETN,
  input wire logic                   CE,
  input wire logic                   PSEL,
  input wire logic                   PENABLE,
  input wire logic [31:0]            PRDATA,
  input wire logic                   PREADY,
  input wire logic                   PSLVERR,
  input wire logic [`CDD_NSRC-1:0]   CLK_SRC,
  input wire logic                   BUS_CLK,
  input wire logic                   CPU_CLK,
  input wire logic                   SEC_TICK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN || !CE);
  // ****************************************************************
  // watch edge count since the last tick
  // ****************************************************************
  logic        watch_prev;
  logic        watch_rise;
  logic [15:0] watch_edges;
  assign watch_rise = CLK_SRC[`CDD_SRC_WATCH] && !watch_prev;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      watch_prev  <= 1'b0;
      watch_edges <= 16'h0000;
    end else if (CE) begin
      watch_prev  <= CLK_SRC[`CDD_SRC_WATCH];
      watch_edges <= (SEC_TICK ? 16'h0000 : watch_edges) + {15'h0000, watch_rise};
    end
  end
  // cpu clock is bus clock halved, so each level lasts two master cycles
  sequence s_cpu_high;
    CPU_CLK [*2];
  endsequence
  sequence s_cpu_low;
    !CPU_CLK [*2];
  endsequence
  a_apb_one_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("apb answer not after one wait state");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held longer than one cycle");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PRDATA == 32'h00000000)
    else $error("error without ready or with data");
  a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h00000000)
    else $error("read data outside answer cycle");
  a_bus_half_rate: assert property ($rose(BUS_CLK) |=> !BUS_CLK ##1 BUS_CLK)
    else $error("bus clock not master divided by two");
  a_cpu_from_bus: assert property ($rose(CPU_CLK) |-> s_cpu_high ##1 s_cpu_low)
    else $error("cpu clock not bus clock divided by two");
  a_tick_one_cycle: assert property (SEC_TICK |=> !SEC_TICK)
    else $error("second tick longer than one cycle");
  a_tick_edge_count: assert property (SEC_TICK |-> watch_edges == SEC_EDGES)
    else $error("second tick at wrong watch edge count");
  a_tick_prompt: assert property (watch_edges == SEC_EDGES |-> ##[0:3] SEC_TICK)
    else $error("second tick missing after watch edges");
endmodule
`default_nettype wire

// >>> bench/test_clock_distribution_dividers.sv
/*
  Self-checking bench of the clock distribution top over APB.
  Assumes sources toggle every k+1 master cycles, interconnect clocks every 7.
*/
`include "cdd_consts.svh"
`default_nettype none
module test_clock_distribution_dividers;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RESETN = 1'b0, CE = 1'b1, USB_ACTIVE = 1'b0;
  logic PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h00000000, PRDATA;
  logic PREADY, PSLVERR, BUS_CLK, CPU_CLK, USB_DIRECT, SEC_TICK, IRQ;
  logic [7:0] DIG_CLK;
  logic [3:0] ANA_CLK;
  logic [1:0] USB_DBL_SRC;
  logic [6:0] tog = 7'h00;
  logic [6:0][2:0] scnt = '0;
  logic [7:0][15:0] dig_hi, dig_lo;
  logic [3:0][15:0] ana_hi, ana_lo;
  int mismatches = 0;
  int n_tests = 0;
  always #10 CLK = ~CLK;
  always @(posedge CLK) begin
    for (int k = 0; k < 7; k++) begin
      if (!RESETN || scnt[k] == 3'(k)) begin
        scnt[k] <= 3'h0;
        tog[k]  <= RESETN ? ~tog[k] : 1'b0;
      end else begin
        scnt[k] <= scnt[k] + 3'h1;
      end
    end
  end
  cdd_clock_dist #(.SEC_EDGES(4)) DUT (.CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_SRC(tog[5:0]), .DSI_CLK({8{tog[6]}}),
    .USB_ACTIVE(USB_ACTIVE), .BUS_CLK(BUS_CLK), .CPU_CLK(CPU_CLK), .DIG_CLK(DIG_CLK),
    .ANA_CLK(ANA_CLK), .USB_DIRECT(USB_DIRECT), .USB_DBL_SRC(USB_DBL_SRC),
    .SEC_TICK(SEC_TICK), .IRQ(IRQ));
  cdd_clk_consumer #(.W(8)) u_dig (.clk(CLK), .resetn(RESETN), .clk_in(DIG_CLK),
    .hi_w(dig_hi), .lo_w(dig_lo));
  cdd_clk_consumer #(.W(4)) u_ana (.clk(CLK), .resetn(RESETN), .clk_in(ANA_CLK),
    .hi_w(ana_hi), .lo_w(ana_lo));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge CLK);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge CLK);
      if (PREADY === 1'b1) break;
    end
    if (i == 16) begin
      mismatches++;
      tally_and_finish();
    end
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h00000000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, exp_err});
  endtask
  task automatic widths(input logic [15:0] hi, input logic [15:0] lo,
                        input logic [15:0] exp_hi, input logic [15:0] exp_lo);
    chk({16'h0, hi}, {16'h0, exp_hi});
    chk({16'h0, lo}, {16'h0, exp_lo});
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs_reset;
    rd_chk(`CDD_OFS_BUS_DIV, 32'h00000002, 1'b0);
    rd_chk(`CDD_OFS_CPU_DIV, 32'h00000002, 1'b0);
    rd_chk(`CDD_OFS_IRQ_EN, 32'h00000000, 1'b0);
    rd_chk(8'h1c, 32'h00000000, 1'b1);
    rd_chk(8'h22, 32'h00000000, 1'b1);
    rd_chk(`CDD_OFS_ANA_END, 32'h00000000, 1'b1);
  endtask
  task automatic t_dig_sources;
    // divide by two: each level lasts one full source period
    for (int i = 0; i < 8; i++)
      wr(`CDD_OFS_DIG_BASE + 8'(4 * i), 32'h00100002 | (32'(i) << 16));
    repeat (80) @(posedge CLK);
    for (int i = 0; i < 8; i++)
      widths(dig_hi[i], dig_lo[i], (i == 6) ? 16'h0001 : (i == 7) ? 16'h000e
             : 16'(2 * (i + 1)), (i == 6) ? 16'h0001 : (i == 7) ? 16'h000e
             : 16'(2 * (i + 1)));
  endtask
  task automatic t_ratios;
    logic [15:0] ns [4] = '{16'h0000, 16'h0003, 16'h0005, 16'h0010};
    for (int j = 0; j < 4; j++) begin
      wr(`CDD_OFS_DIG_BASE, 32'h00160000 | {16'h0, ns[j]});
      repeat (60) @(posedge CLK);
      widths(dig_hi[0], dig_lo[0], (ns[j] < 2) ? 16'h0001 : (ns[j] + 16'h0001) >> 1,
             (ns[j] < 2) ? 16'h0001 : ns[j] >> 1);
    end
  endtask
  task automatic t_chain_analog;
    wr(`CDD_OFS_DIG_BASE, 32'h00160002);
    wr(`CDD_OFS_DIG_BASE + 8'h04, 32'h001f0003);
    wr(`CDD_OFS_ANA_BASE, 32'h00f60003);
    repeat (60) @(posedge CLK);
    widths(dig_hi[1], dig_lo[1], 16'h0004, 16'h0002);
    widths(ana_hi[0], ana_lo[0], 16'h0002, 16'h0001);
  endtask
  task automatic t_sec_irq;
    int i;
    wr(`CDD_OFS_IRQ_CLR, 32'h00000003);
    wr(`CDD_OFS_IRQ_EN, 32'h00000001);
    for (i = 0; i < 60 && IRQ !== 1'b1; i++)
      @(posedge CLK);
    chk({31'h0, IRQ}, 32'h00000001);
    wr(`CDD_OFS_IRQ_STAT, 32'h00000000);
    rd_chk(`CDD_OFS_IRQ_STAT, 32'h00000001, 1'b0);
    rd_chk(`CDD_OFS_IRQ_CLR, 32'h00000000, 1'b0);
    wr(`CDD_OFS_IRQ_CLR, 32'h00000001);
    repeat (2) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h00000000);
    wr(`CDD_OFS_IRQ_EN, 32'h00000000);
    wr(`CDD_OFS_DIG_BASE + 8'h08, 32'h00160004);
    repeat (40) @(posedge CLK);
    chk({31'h0, IRQ}, 32'h00000000);
    rd_chk(`CDD_OFS_IRQ_STAT, 32'h00000003, 1'b0);
  endtask
  task automatic t_usb;
    for (int s = 0; s < 3; s++) begin
      wr(`CDD_OFS_USB_CTRL, 32'(s) << 1);
      repeat (2) @(posedge CLK);
      chk({29'h0, USB_DBL_SRC, USB_DIRECT}, 32'(s) << 1);
    end
    wr(`CDD_OFS_USB_CTRL, 32'h00000001);
    repeat (2) @(posedge CLK);
    chk({29'h0, USB_DBL_SRC, USB_DIRECT}, 32'h00000001);
    USB_ACTIVE <= 1'b1;
    repeat (4) @(posedge CLK);
    rd_chk(`CDD_OFS_USB_CTRL, 32'h00000101, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    t_regs_reset();
    t_dig_sources();
    t_ratios();
    t_chain_analog();
    t_sec_irq();
    t_usb();
    tally_and_finish();
  end
endmodule
bind cdd_clock_dist cdd_clock_dist_props #(.SEC_EDGES(SEC_EDGES)) u_props (.CLK(CLK),
  .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .CLK_SRC(CLK_SRC), .BUS_CLK(BUS_CLK),
  .CPU_CLK(CPU_CLK), .SEC_TICK(SEC_TICK));
`default_nettype wire

// >>> rtl/cdd_clock_dist.sv
/*
  Central clock distribution: bus and cpu dividers, eight digital and four
  analog dividers, usb clock steering, one-second watch tick, APB registers.
  Assumes all clock sources and interconnect clocks are sampled levels
  synchronous to CLK, the master clock; USB_ACTIVE comes from the usb domain.
*/
// Functional notes
// (RULE1) each divider picks input through eight-way mux
// (RULE2) 16-bit counter, ratio two up, half duty
// (RULE3) outputs resynchronised to master, no runt pulses
// (RULE4) digital outputs chain back as divider inputs
// (RULE5) bus clock divided from master clock
// (RULE6) cpu divider clocked from bus clock
// (RULE7) eight digital dividers, any of seven sources
// (RULE8) four analog dividers with adjustable skew
// (RULE9) eight extra interconnect clocks, one per divider
// (RULE10) master clock is the reference for synchronising
// (RULE11) usb 48 MHz direct or doubled 24 MHz
// (RULE12) usb status crosses into bus domain safely
// (RULE13) watch clock gives one-second tick interrupt
// (RULE14) divider settings change only at period end
`include "cdd_consts.svh"
`default_nettype none

module cdd_clock_dist #(
  parameter int SEC_EDGES = `CDD_SEC_EDGES
) (
  input  wire logic                        CLK,
  input  wire logic                        RESETN,
  input  wire logic                        CE,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [7:0]                  PADDR,
  input  wire logic [31:0]                 PWDATA,
  output var  logic [31:0]                 PRDATA,
  output var  logic                        PREADY,
  output var  logic                        PSLVERR,
  input  wire logic [`CDD_NSRC-1:0]        CLK_SRC,
  input  wire logic [`CDD_NDIG-1:0]        DSI_CLK,
  input  wire logic                        USB_ACTIVE,
  output var  logic                        BUS_CLK,
  output var  logic                        CPU_CLK,
  output var  logic [`CDD_NDIG-1:0]        DIG_CLK,
  output var  logic [`CDD_NANA-1:0]        ANA_CLK,
  output var  logic                        USB_DIRECT,
  output var  logic [1:0]                  USB_DBL_SRC,
  output var  logic                        SEC_TICK,
  output var  logic                        IRQ
);
  import cdd_pkg::*;

  // ****************************************************************
  // state and nets
  // ****************************************************************
  cdd_top_state_t            s;
  cdd_top_state_t            next_s;
  logic [`CDD_NSRC-1:0]      src_edge;
  logic [`CDD_NDIG-1:0]      dsi_edge;
  logic [`CDD_NDIG-1:0]      dig_out;
  logic [`CDD_NDIG-1:0]      dig_edge;
  logic [`CDD_NDIG-1:0]      dig_loaded;
  logic [`CDD_NANA-1:0]      ana_raw;
  logic [`CDD_NANA-1:0]      ana_loaded;
  logic                      bus_out;
  logic                      bus_edge;
  logic                      bus_loaded;
  logic                      cpu_out;
  logic                      cpu_loaded;
  logic                      access;
  logic                      wr;
  logic                      mapped;
  logic [31:0]               rdata;
  logic [`CDD_NIRQ-1:0]      irq_set;
  logic [`CDD_NIRQ-1:0]      irq_clr;
  logic [2:0]                idx;

  // ****************************************************************
  // edge pulses on the master clock
  // ****************************************************************
  // every source is seen through the master clock, so all trees share it
  assign src_edge = CLK_SRC & ~s.src_prev;  // RULE10
  assign dsi_edge = DSI_CLK & ~s.dsi_prev;
  assign dig_edge = dig_out & ~s.dig_prev;
  assign bus_edge = bus_out & ~s.bus_prev;

  // ****************************************************************
  // bus and cpu dividers
  // ****************************************************************
  // master index always has an edge: the bus divider counts master cycles
  cdd_divider u_bus (
    .clk      (CLK),
    .resetn   (RESETN),
    .ce       (CE),
    .src_edge (8'hff),  // RULE5
    .sel      (`CDD_SRC_MASTER),
    .div      (s.bus_div),
    .en       (1'b1),
    .clk_out  (bus_out),
    .loaded   (bus_loaded)
  );

  cdd_divider u_cpu (
    .clk      (CLK),
    .resetn   (RESETN),
    .ce       (CE),
    .src_edge ({8{bus_edge}}),  // RULE6
    .sel      (`CDD_SRC_MASTER),
    .div      (s.cpu_div),
    .en       (1'b1),
    .clk_out  (cpu_out),
    .loaded   (cpu_loaded)
  );

  // ****************************************************************
  // digital dividers
  // ****************************************************************
  // input 7 is the divider's own interconnect clock, or the previous
  // divider's output when chaining is set
  for (genvar i = 0; i < `CDD_NDIG; i++) begin : g_dig
    logic [7:0] edges;
    logic       chain_edge;
    assign chain_edge = dig_edge[(i + `CDD_NDIG - 1) % `CDD_NDIG];
    assign edges = {s.dig_cfg[i][`CDD_F_CHAIN] ? chain_edge  // RULE4
                                               : dsi_edge[i],  // RULE9
                    1'b1, src_edge};  // RULE7
    cdd_divider u_div (
      .clk      (CLK),
      .resetn   (RESETN),
      .ce       (CE),
      .src_edge (edges),
      .sel      (s.dig_cfg[i][`CDD_F_SEL_LSB +: `CDD_SELW]),
      .div      (s.dig_cfg[i][`CDD_F_DIV_LSB +: `CDD_DIVW]),
      .en       (s.dig_cfg[i][`CDD_F_EN]),
      .clk_out  (dig_out[i]),
      .loaded   (dig_loaded[i])
    );
  end

  // ****************************************************************
  // analog dividers
  // ****************************************************************
  // input 7 takes the digital tree of the same number
  for (genvar j = 0; j < `CDD_NANA; j++) begin : g_ana
    cdd_divider u_div (
      .clk      (CLK),
      .resetn   (RESETN),
      .ce       (CE),
      .src_edge ({dig_edge[j], 1'b1, src_edge}),
      .sel      (s.ana_cfg[j][`CDD_F_SEL_LSB +: `CDD_SELW]),
      .div      (s.ana_cfg[j][`CDD_F_DIV_LSB +: `CDD_DIVW]),
      .en       (s.ana_cfg[j][`CDD_F_EN]),
      .clk_out  (ana_raw[j]),
      .loaded   (ana_loaded[j])
    );
  end

  // ****************************************************************
  // register read mux
  // ****************************************************************
  function automatic logic [31:0] read_word(input cdd_top_state_t st,
                                            input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    if (a >= `CDD_OFS_DIG_BASE && a < `CDD_OFS_ANA_BASE) begin
      w = {8'h00, st.dig_cfg[a[4:2]]};
    end else if (a >= `CDD_OFS_ANA_BASE && a < `CDD_OFS_ANA_END) begin
      w = {8'h00, st.ana_cfg[a[3:2]]};
    end else begin
      case (a)
        `CDD_OFS_BUS_DIV:  w = {16'h0000, st.bus_div};
        `CDD_OFS_CPU_DIV:  w = {16'h0000, st.cpu_div};
        `CDD_OFS_USB_CTRL: w = {23'h000000, st.usb_s2, 5'h00, st.usb_ctrl};
        `CDD_OFS_IRQ_STAT: w = {30'h00000000, st.irq_stat};
        `CDD_OFS_IRQ_EN:   w = {30'h00000000, st.irq_en};
        default:           w = 32'h00000000;
      endcase
    end
    return w;
  endfunction

  always_comb begin
    mapped = (PADDR[1:0] == 2'b00) &&
             ((PADDR < `CDD_OFS_ANA_END && PADDR >= `CDD_OFS_DIG_BASE) ||
              PADDR <= `CDD_OFS_CLK_STAT);
    if (PADDR == `CDD_OFS_CLK_STAT) begin
      // live view of every generated clock
      rdata = {14'h0000, s.ana_out, dig_out, 4'h0, cpu_out, bus_out};
    end else if (PADDR == `CDD_OFS_IRQ_CLR) begin
      rdata = 32'h00000000;
    end else begin
      rdata = read_word(s, PADDR);
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_s = s;
    idx = PADDR[4:2];
    access = PSEL && PENABLE;
    wr = access && s.pready && PWRITE && mapped;
    irq_clr = '0;

    // apb: one wait state, answer registered
    next_s.pready = access && !s.pready;
    next_s.pslverr = access && !s.pready && !mapped;
    next_s.prdata = (access && !s.pready && !PWRITE && mapped) ? rdata : 32'h00000000;

    if (wr) begin
      if (PADDR >= `CDD_OFS_DIG_BASE && PADDR < `CDD_OFS_ANA_BASE) begin
        next_s.dig_cfg[idx] = PWDATA[`CDD_CFGW-1:0];
      end else if (PADDR >= `CDD_OFS_ANA_BASE && PADDR < `CDD_OFS_ANA_END) begin
        next_s.ana_cfg[idx[1:0]] = PWDATA[`CDD_CFGW-1:0];
      end else begin
        case (PADDR)
          `CDD_OFS_BUS_DIV:  next_s.bus_div = PWDATA[`CDD_DIVW-1:0];
          `CDD_OFS_CPU_DIV:  next_s.cpu_div = PWDATA[`CDD_DIVW-1:0];
          `CDD_OFS_USB_CTRL: next_s.usb_ctrl = PWDATA[2:0];
          `CDD_OFS_IRQ_CLR:  irq_clr = PWDATA[`CDD_NIRQ-1:0];
          `CDD_OFS_IRQ_EN:   next_s.irq_en = PWDATA[`CDD_NIRQ-1:0];
          default:           next_s.irq_en = s.irq_en;
        endcase
      end
    end

    // edge history
    next_s.src_prev = CLK_SRC;
    next_s.dsi_prev = DSI_CLK;
    next_s.dig_prev = dig_out;
    next_s.bus_prev = bus_out;

    // analog skew: delay line on master cycles, tap chosen per divider
    for (int k = 0; k < `CDD_NANA; k++) begin
      next_s.skew_line[k] = {s.skew_line[k][`CDD_SKEW_TAPS-2:0], ana_raw[k]};  // RULE8
      next_s.ana_out[k] = s.skew_line[k][s.ana_cfg[k][`CDD_F_SKEW_LSB +: `CDD_SKEWW]];
    end

    // one-second tick counted on watch crystal edges
    next_s.sec_tick = 1'b0;
    if (src_edge[`CDD_SRC_WATCH]) begin  // RULE13
      if (s.sec_cnt >= 16'(SEC_EDGES - 1)) begin
        next_s.sec_cnt = 16'h0000;
        next_s.sec_tick = 1'b1;
      end else begin
        next_s.sec_cnt = s.sec_cnt + 16'h0001;
      end
    end

    // usb activity: two-flop crossing from the usb domain
    next_s.usb_s1 = USB_ACTIVE;  // RULE12
    next_s.usb_s2 = s.usb_s1;

    // sticky status: a set in the clear cycle survives
    irq_set = '0;
    irq_set[`CDD_IRQ_SECOND] = s.sec_tick;
    irq_set[`CDD_IRQ_LOADED] = |{dig_loaded, ana_loaded, bus_loaded, cpu_loaded};
    next_s.irq_stat = (s.irq_stat & ~irq_clr) | irq_set;
    next_s.irq = |(next_s.irq_stat & next_s.irq_en);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      s <= '0;
      s.bus_div <= `CDD_BUS_DIV_RST;
      s.cpu_div <= `CDD_CPU_DIV_RST;
      s.usb_ctrl <= `CDD_USB_RST;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign BUS_CLK = bus_out;
  assign CPU_CLK = cpu_out;
  assign DIG_CLK = dig_out;
  assign ANA_CLK = s.ana_out;
  // the doubler itself is analog; this block only steers it
  assign USB_DIRECT = s.usb_ctrl[`CDD_F_USB_DIRECT];  // RULE11
  assign USB_DBL_SRC = s.usb_ctrl[`CDD_F_USB_SRC_LSB +: 2];
  assign SEC_TICK = s.sec_tick;
  assign IRQ = s.irq;

endmodule

`default_nettype wire

// >>> rtl/cdd_consts.svh
/*
  Constants of the clock distribution block: register offsets, field positions,
  reset values and timing counts. Assumes inclusion by bare name from rtl/.
*/
`ifndef CDD_CONSTS_SVH
`define CDD_CONSTS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define CDD_DIVW          16
`define CDD_SELW          3
`define CDD_NSRC          6
`define CDD_NDIG          8
`define CDD_NANA          4
`define CDD_CFGW          24
`define CDD_SKEWW         3
`define CDD_SKEW_TAPS     8
`define CDD_NIRQ          2

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CDD_OFS_BUS_DIV   8'h00
`define CDD_OFS_CPU_DIV   8'h04
`define CDD_OFS_USB_CTRL  8'h08
`define CDD_OFS_IRQ_STAT  8'h0c
`define CDD_OFS_IRQ_CLR   8'h10
`define CDD_OFS_IRQ_EN    8'h14
`define CDD_OFS_CLK_STAT  8'h18
`define CDD_OFS_DIG_BASE  8'h20
`define CDD_OFS_ANA_BASE  8'h40
`define CDD_OFS_ANA_END   8'h50

// ****************************************************************
// divider config word fields
// ****************************************************************
`define CDD_F_DIV_LSB     0
`define CDD_F_SEL_LSB     16
`define CDD_F_CHAIN       19
`define CDD_F_EN          20
`define CDD_F_SKEW_LSB    21

// ****************************************************************
// usb control fields
// ****************************************************************
`define CDD_F_USB_DIRECT  0
`define CDD_F_USB_SRC_LSB 1
`define CDD_F_USB_ACT     8

// ****************************************************************
// interrupt bits
// ****************************************************************
`define CDD_IRQ_SECOND    0
`define CDD_IRQ_LOADED    1

// ****************************************************************
// reset values, minimum ratio and source indices
// ****************************************************************
`define CDD_BUS_DIV_RST   16'h0002
`define CDD_CPU_DIV_RST   16'h0002
`define CDD_CFG_RST       24'h000000
`define CDD_USB_RST       3'h0
`define CDD_MIN_DIV       16'h0002
`define CDD_SRC_MASTER    3'h6
`define CDD_SRC_WATCH     2

// ****************************************************************
// timing: watch crystal 32768 Hz, one second of its edges
// ****************************************************************
`define CDD_WATCH_HZ      32768
`define CDD_SEC_SECONDS   1
`define CDD_SEC_EDGES     (`CDD_WATCH_HZ * `CDD_SEC_SECONDS)

`endif

// >>> rtl/cdd_divider.sv
/*
  One clock divider: eight-way source select, 16-bit divide-by-N counter,
  output regenerated on the master clock. Assumes source edges arrive as
  one-cycle pulses already aligned to the master clock.
*/
`include "cdd_consts.svh"
`default_nettype none

module cdd_divider (
  input  wire logic                    clk,
  input  wire logic                    resetn,
  input  wire logic                    ce,
  input  wire logic [7:0]              src_edge,
  input  wire logic [`CDD_SELW-1:0]    sel,
  input  wire cdd_pkg::cdd_div_t       div,
  input  wire logic                    en,
  output var  logic                    clk_out,
  output var  logic                    loaded
);
  import cdd_pkg::*;

  cdd_divider_state_t s;
  cdd_divider_state_t next_s;
  cdd_div_t           eff;
  logic [16:0]        half;
  logic               changed;

  always_comb begin
    next_s = s;
    next_s.loaded = 1'b0;
    // ratios below two act as two
    eff = (s.div_act < `CDD_MIN_DIV) ? `CDD_MIN_DIV : s.div_act;  // RULE2
    half = ({1'b0, eff} + 17'h00001) >> 1;
    changed = (div != s.div_act) || (sel != s.sel_act);
    if (!en) begin
      next_s.cnt = '0;
      next_s.out = 1'b0;
      next_s.div_act = div;
      next_s.sel_act = sel;
    end else if (src_edge[s.sel_act]) begin  // RULE1
      if (s.cnt >= eff - `CDD_MIN_DIV + 16'h0001) begin
        next_s.cnt = '0;
        next_s.out = 1'b1;
        // new settings only at a period boundary
        if (changed) begin  // RULE14
          next_s.div_act = div;
          next_s.sel_act = sel;
          next_s.loaded = 1'b1;
        end
      end else begin
        next_s.cnt = s.cnt + 16'h0001;
        next_s.out = ({1'b0, s.cnt} + 17'h00001) < half;  // RULE2
      end
    end
  end

  // output only moves on a master edge, with a counted source edge or while disabled: no runts
  always_ff @(posedge clk) begin  // RULE3
    if (!resetn) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign clk_out = s.out;
  assign loaded = s.loaded;

endmodule

`default_nettype wire

// >>> rtl/cdd_pkg.sv
/*
  Types of the clock distribution block: state records of top and divider.
  Assumes cdd_consts.svh sits beside it.
*/
`include "cdd_consts.svh"
`default_nettype none

package cdd_pkg;

  typedef logic [`CDD_DIVW-1:0] cdd_div_t;
  typedef logic [`CDD_CFGW-1:0] cdd_cfg_t;

  typedef struct packed {
    cdd_div_t                cnt;
    cdd_div_t                div_act;
    logic [`CDD_SELW-1:0]    sel_act;
    logic                    out;
    logic                    loaded;
  } cdd_divider_state_t;

  typedef struct packed {
    cdd_cfg_t [`CDD_NDIG-1:0]                      dig_cfg;
    cdd_cfg_t [`CDD_NANA-1:0]                      ana_cfg;
    cdd_div_t                                      bus_div;
    cdd_div_t                                      cpu_div;
    logic [2:0]                                    usb_ctrl;
    logic [`CDD_NIRQ-1:0]                          irq_stat;
    logic [`CDD_NIRQ-1:0]                          irq_en;
    logic [`CDD_NSRC-1:0]                          src_prev;
    logic [`CDD_NDIG-1:0]                          dsi_prev;
    logic [`CDD_NDIG-1:0]                          dig_prev;
    logic                                          bus_prev;
    logic [`CDD_NANA-1:0][`CDD_SKEW_TAPS-1:0]      skew_line;
    logic [`CDD_NANA-1:0]                          ana_out;
    logic [15:0]                                   sec_cnt;
    logic                                          sec_tick;
    logic                                          usb_s1;
    logic                                          usb_s2;
    logic                                          pready;
    logic                                          pslverr;
    logic [31:0]                                   prdata;
    logic                                          irq;
  } cdd_top_state_t;

endpackage

`default_nettype wire
